// ==== hw/bus_pipe_snoop.sv ====
`include "bus_pipe_cfg.svh"
module bus_pipe_snoop (
  input wire logic clock, // bus clock
  input wire logic rst_n, // sync reset
  input wire logic req_valid, // core cycle request
  input wire logic req_write, // request is write
  input wire logic req_atomic, // request is locked
  input wire logic req_wback, // replacement writeback
  input wire logic req_burst, // four beats
  input wire bus_pipe_pkg::addr_t req_addr, // request address
  input wire logic [7:0] req_be, // request byte enables
  input wire logic [255:0] wr_line, // write data, beat 0 low
  output logic req_taken, // request issued pulse
  output logic [63:0] rd_data, // read beat data
  output logic rd_valid, // read beat pulse
  output logic attr_valid, // attribute sample pulse
  output logic attr_cacheable, // sampled cacheable_in
  output logic attr_wb_policy, // sampled write_policy_in
  output logic lookup_valid, // snoop lookup strobe
  output bus_pipe_pkg::line_t lookup_line, // snoop line address
  output logic lookup_drop, // invalidate, else share
  input wire logic lookup_hit, // hit either cache
  input wire logic lookup_modified, // hit modified data line
  input wire logic [255:0] snoop_line_data, // modified line data
  input wire logic wb_cancel, // modified line vanished
  input wire logic sram_mode, // cache in sram mode
  input wire logic hold_req_in, // bus hold request
  output logic hold_grant_out, // bus hold grant
  output logic cycle_start_strobe, // address strobe
  output logic cycle_write, // cycle direction
  output logic atomic_seq_out, // locked sequence
  output bus_pipe_pkg::addr_t addr_out, // address pins out
  output logic addr_parity_bit_out, // address parity out
  output logic addr_oe, // address pins driven
  input wire bus_pipe_pkg::addr_t addr_in, // inquire address
  input wire logic addr_parity_bit_in, // inquire parity
  output logic [7:0] be_out, // byte enables
  output logic [63:0] data_out, // write data pins
  output logic [7:0] data_par_out, // write data parity
  output logic data_oe, // data pins driven
  input wire logic [63:0] data_in, // read data pins
  input wire logic [7:0] data_par_in, // read data parity
  input wire logic burst_ready, // beat done
  input wire logic next_cycle_ok, // next address allowed
  input wire logic cacheable_in, // cacheable
  input wire logic write_policy_in, // write-back policy
  input wire logic addr_float_req, // float address bus
  input wire logic ext_snoop_strobe, // inquire strobe
  input wire logic snoop_drop_line, // invalidate on hit
  input wire logic bus_backoff_in, // backoff
  output logic data_parity_err_out, // read parity error
  output logic addr_parity_err_out, // inquire parity error
  output logic snoop_match_out, // low on hit
  output logic snoop_modified_out // modified hit
);
  import bus_pipe_pkg::*;

  slot_s s0_q, s1_q, s0_d, s1_d, new_slot;
  logic v0_q, v1_q, v0_d, v1_d;
  logic na_q, td_q, td_d, ads_d1_q, ext_snoop_strobe_d1_q;
  logic burst_ready_ok, last0, samp, wb_go, req_go, issue, pipe_room, snoop_take;
  logic hit2_q, mod2_q, v2_q, dup2_q, ape1_q, ape2_q, dup_now;
  logic [1:0] wb_cnt_q;
  line_t wb_line_q;
  logic [255:0] wb_data_q;
  logic [7:0] gen_par, chk_par;
  logic [63:0] word_d;
  wb_state_e wb_st_q;

  function automatic logic holds_line(input logic v, input slot_s s, input line_t l);
    holds_line = v && s.wback && (s.addr[28:`BPS_LINE_LSB] == l);
  endfunction

  // dead clock ignores ready
  // R7: ready masked in dead clock
  assign burst_ready_ok = burst_ready && v0_q && !td_q;
  assign last0 = burst_ready_ok && (s0_q.beat == s0_q.last);

  // R5: no pipelining of locked or writeback
  assign pipe_room = !v1_q && na_q && !s0_q.atomic && !s0_q.wback;

  // R18: writeback after gap, no backoff or hold
  assign wb_go = (wb_st_q == WB_HOLD) && (wb_cnt_q == `BPS_WB_GAP - 2'h1) && !v0_q
    && !bus_backoff_in && !hold_grant_out && !wb_cancel;

  // R8: third cycle waits for a free slot
  assign req_go = req_valid && !req_taken && !addr_float_req && !bus_backoff_in
    && !hold_req_in && !hold_grant_out && (wb_st_q != WB_HOLD)
    && (!v0_q || (pipe_room && !req_atomic && !req_wback));
  assign issue = wb_go || req_go;

  always_comb begin
    new_slot = '0;
    if (wb_go) begin
      new_slot.write = 1'b1;
      new_slot.wback = 1'b1;
      new_slot.last = `BPS_BURST_LAST;
      // R18: writeback begins at beat zero
      new_slot.addr = {wb_line_q, `BPS_WB_BEAT0};
      new_slot.be = `BPS_WB_BE;
      new_slot.line = wb_data_q;
    end else begin
      new_slot.write = req_write;
      new_slot.atomic = req_atomic;
      new_slot.wback = req_wback;
      new_slot.last = (req_burst || req_wback) ? `BPS_BURST_LAST : `BPS_SINGLE_LAST;
      new_slot.addr = req_addr;
      new_slot.be = req_be;
      new_slot.line = wr_line;
    end
    new_slot.td = v0_q && (new_slot.write != s0_q.write);
  end

  always_comb begin
    s0_d = s0_q;
    s1_d = s1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    samp = 1'b0;
    // R3: sample at first of next-ok or ready
    if (v0_q && !s0_q.sampled && (next_cycle_ok || burst_ready_ok)) begin
      s0_d.sampled = 1'b1;
      samp = 1'b1;
    // R9: second cycle sampled only by next-ok here
    end else if (v1_q && s0_q.sampled && !s1_q.sampled && next_cycle_ok) begin
      s1_d.sampled = 1'b1;
      samp = 1'b1;
    end
    if (burst_ready_ok) begin
      s0_d.beat = s0_q.beat + 2'h1;
    end
    if (last0) begin
      s0_d = s1_d;
      v0_d = v1_q;
      v1_d = 1'b0;
    end
    if (issue) begin
      if (!v0_d) begin
        s0_d = new_slot;
        v0_d = 1'b1;
      end else begin
        s1_d = new_slot;
        v1_d = 1'b1;
      end
    end
  end

  // R7: dead clock on type change
  assign td_d = last0 && v1_q && s1_q.td;
  assign word_d = s0_d.line[s0_d.beat];

  byte_parity #(.BYTES(8)) u_gen (
    .data(word_d),
    .par(gen_par)
  );

  byte_parity #(.BYTES(8)) u_chk (
    .data(data_in),
    .par(chk_par)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s0_q <= '0;
      s1_q <= '0;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      td_q <= 1'b0;
    end else begin
      s0_q <= s0_d;
      s1_q <= s1_d;
      v0_q <= v0_d;
      v1_q <= v1_d;
      td_q <= td_d;
    end
  end

  // latched next-address permission
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      na_q <= 1'b0;
    end else if (last0) begin
      na_q <= next_cycle_ok && v1_q;
    end else if (issue && v0_q) begin
      na_q <= 1'b0;
    end else if (next_cycle_ok && v0_q) begin
      // R4: permission held until used
      na_q <= 1'b1;
    end
  end

  // address phase pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cycle_start_strobe <= 1'b0;
      cycle_write <= 1'b0;
      atomic_seq_out <= 1'b0;
      addr_out <= '0;
      addr_parity_bit_out <= 1'b0;
      addr_oe <= 1'b0;
      be_out <= '0;
      req_taken <= 1'b0;
      ads_d1_q <= 1'b0;
    end else begin
      // R6: strobe one clock after latched permission
      cycle_start_strobe <= issue;
      req_taken <= req_go && !wb_go;
      ads_d1_q <= cycle_start_strobe;
      atomic_seq_out <= v0_d && s0_d.atomic;
      if (issue) begin
        cycle_write <= new_slot.write;
        addr_out <= new_slot.addr;
        be_out <= new_slot.be;
        // R2: even parity over line address
        addr_parity_bit_out <= ^new_slot.addr[28:`BPS_LINE_LSB];
      end
      // R19: pins float while float requested
      addr_oe <= v0_d && !addr_float_req && !bus_backoff_in && !hold_grant_out;
    end
  end

  // data phase pins and read capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_out <= '0;
      data_par_out <= '0;
      data_oe <= 1'b0;
      rd_data <= '0;
      rd_valid <= 1'b0;
      data_parity_err_out <= 1'b0;
      attr_valid <= 1'b0;
      attr_cacheable <= 1'b0;
      attr_wb_policy <= 1'b0;
    end else begin
      data_out <= word_d;
      // R1: even parity per write byte
      data_par_out <= gen_par & s0_d.be;
      data_oe <= v0_d && s0_d.write && !td_d && !bus_backoff_in;
      rd_valid <= burst_ready_ok && !s0_q.write;
      if (burst_ready_ok && !s0_q.write) begin
        rd_data <= data_in;
      end
      // R1: check enabled read bytes
      data_parity_err_out <= burst_ready_ok && !s0_q.write
        && |((chk_par ^ data_par_in) & s0_q.be);
      attr_valid <= samp;
      if (samp) begin
        attr_cacheable <= cacheable_in;
        attr_wb_policy <= write_policy_in;
      end
    end
  end

  // R16: strobe ignored in listed clocks
  assign snoop_take = ext_snoop_strobe && !snoop_modified_out && !ads_d1_q
    && !ext_snoop_strobe_d1_q && !sram_mode && !addr_oe;
  // R22: line already in a writeback slot
  assign dup_now = holds_line(v0_q, s0_q, lookup_line) || holds_line(v1_q, s1_q, lookup_line);

  // inquiry pipeline, results two clocks on
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_snoop_strobe_d1_q <= 1'b0;
      lookup_valid <= 1'b0;
      lookup_line <= '0;
      lookup_drop <= 1'b0;
      ape1_q <= 1'b0;
      v2_q <= 1'b0;
      hit2_q <= 1'b0;
      mod2_q <= 1'b0;
      dup2_q <= 1'b0;
      ape2_q <= 1'b0;
      snoop_match_out <= `BPS_MATCH_MISS;
      addr_parity_err_out <= 1'b0;
    end else begin
      ext_snoop_strobe_d1_q <= ext_snoop_strobe;
      lookup_valid <= snoop_take;
      if (snoop_take) begin
        // R12: low address bits ignored
        lookup_line <= addr_in[28:`BPS_LINE_LSB];
        // R13: drop selects invalidate or share
        lookup_drop <= snoop_drop_line;
        ape1_q <= ^{addr_in[28:`BPS_LINE_LSB], addr_parity_bit_in};
      end
      // R21: parity error leaves lookup running
      v2_q <= lookup_valid;
      if (lookup_valid) begin
        hit2_q <= lookup_hit;
        mod2_q <= lookup_modified;
        dup2_q <= dup_now;
        ape2_q <= ape1_q;
      end
      if (v2_q) begin
        // R14: low on hit, held otherwise
        snoop_match_out <= !hit2_q;
        // R2: parity result two clocks after lookup strobe
        addr_parity_err_out <= ape2_q;
      end
    end
  end

  // snoop writeback sequencing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wb_st_q <= WB_IDLE;
      wb_cnt_q <= '0;
      wb_line_q <= '0;
      wb_data_q <= '0;
      snoop_modified_out <= 1'b0;
    end else begin
      if (lookup_valid && lookup_modified && wb_st_q == WB_IDLE) begin
        wb_line_q <= lookup_line;
        wb_data_q <= snoop_line_data;
      end
      case (wb_st_q)
        WB_IDLE: begin
          // R20: only external inquiry hits raise it
          // R15: modified with match, two clocks on
          if (v2_q && mod2_q) begin
            snoop_modified_out <= 1'b1;
            wb_cnt_q <= '0;
            // R22: no second writeback for same line
            wb_st_q <= dup2_q ? WB_RUN : WB_HOLD;
          end
        end
        WB_HOLD: begin
          if (wb_cancel) begin
            // R22: drop without writeback
            snoop_modified_out <= 1'b0;
            wb_st_q <= WB_IDLE;
          end else if (wb_go) begin
            wb_st_q <= WB_RUN;
          end else if (wb_cnt_q != `BPS_WB_GAP - 2'h1) begin
            wb_cnt_q <= wb_cnt_q + 2'h1;
          end
        end
        WB_RUN: begin
          if ((last0 && holds_line(v0_q, s0_q, wb_line_q))
              || !(holds_line(v0_q, s0_q, wb_line_q) || holds_line(v1_q, s1_q, wb_line_q))) begin
            wb_cnt_q <= '0;
            wb_st_q <= WB_TAIL;
          end
        end
        WB_TAIL: begin
          // R15: held two clocks past last ready
          if (wb_cnt_q == `BPS_SNOOP_MODIFIED_OUT_TAIL - 2'h1) begin
            snoop_modified_out <= 1'b0;
            wb_st_q <= WB_IDLE;
          end else begin
            wb_cnt_q <= wb_cnt_q + 2'h1;
          end
        end
        default: begin
          wb_st_q <= WB_IDLE;
        end
      endcase
    end
  end

  // bus hold grant between cycles
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_grant_out <= 1'b0;
    end else begin
      hold_grant_out <= hold_req_in && !v0_d;
    end
  end
endmodule

// ==== hw/byte_parity.sv ====
module byte_parity #(
  parameter int BYTES = 8
) (
  input wire logic [BYTES*8-1:0] data, // data word
  output logic [BYTES-1:0] par // even parity per byte
);
  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : g_byte
      assign par[i] = ^data[i*8 +: 8];
    end
  endgenerate
endmodule

// ==== shared/bus_pipe_cfg.svh ====
// Function
// R1: Even parity per enabled write byte; read bytes checked, error flagged.
// R2: Address parity over line address; inquire check reported two clocks after strobe.
// R3: Cacheability and policy sampled at first of next-cycle-ok or first ready.
// R4: Next-cycle-ok is latched; later pending cycle still issued.
// R5: Atomic and writeback cycles never pipelined either way.
// R6: Pending cycle starts two clocks after next-cycle-ok sampled.
// R7: Read/write type change between pipelined cycles inserts one dead clock.
// R8: At most two cycles outstanding; third waits for first to finish.
// R9: Ready of first cycle never samples attributes of the second.
// R10: Far side keeps ready low during the turnaround dead clock.
// R11: Far side floats address, waits two clocks, then strobes inquiry.
// R12: Inquiry uses line address only; low address bits ignored.
// R13: Hit invalidates line when drop is high, else marks shared.
// R14: Match output low on hit, high on miss, held between inquiries.
// R15: Modified output with match two clocks after; held until writeback ends plus two.
// R16: Snoop strobe ignored in writeback, after strobes, in SRAM mode, or driving address.
// R17: Far side blocks inquiries during self test; releases float carefully.
// R18: Writeback starts two clocks after modified, at beat zero, after backoff/hold released.
// R19: Writeback may start while address floats; address driven once float released.
// R20: Modified output only for external inquiry hits, not internal writebacks.
// R21: Address parity error does not stop the lookup or writeback.
// R22: Modified may drop without writeback; no second writeback for same line.
`ifndef BUS_PIPE_CFG_SVH
`define BUS_PIPE_CFG_SVH
`define BPS_WB_GAP 2'h2
`define BPS_SNOOP_MODIFIED_OUT_TAIL 2'h2
`define BPS_BURST_LAST 2'h3
`define BPS_SINGLE_LAST 2'h0
`define BPS_WB_BEAT0 2'h0
`define BPS_WB_BE 8'hFF
`define BPS_MATCH_MISS 1'b1
`define BPS_LINE_LSB 2
`endif

// ==== shared/bus_pipe_pkg.sv ====
package bus_pipe_pkg;
  typedef logic [28:0] addr_t;
  typedef logic [26:0] line_t;
  typedef struct packed {
    logic write;
    logic atomic;
    logic wback;
    logic sampled;
    logic td;
    logic [1:0] beat;
    logic [1:0] last;
    addr_t addr;
    logic [7:0] be;
    logic [3:0][63:0] line;
  } slot_s;
  typedef enum {WB_IDLE, WB_HOLD, WB_RUN, WB_TAIL} wb_state_e;
endpackage

// ==== verification/bus_pipe_snoop_props.sv ====
module bus_pipe_snoop_props (
  input wire logic clock, // clock
  input wire logic rst_n, // reset
  input wire logic ext_snoop_strobe, // strobe
  input wire logic snoop_drop_line, // drop
  input wire bus_pipe_pkg::addr_t addr_in, // address
  input wire logic addr_parity_bit_in, // parity
  input wire logic sram_mode, // sram
  input wire logic addr_oe, // driven
  input wire logic cycle_start_strobe, // start
  input wire logic addr_float_req, // float
  input wire logic lookup_valid, // lookup
  input wire bus_pipe_pkg::line_t lookup_line, // line
  input wire logic lookup_drop, // drop
  input wire logic lookup_hit, // hit
  input wire logic lookup_modified, // modified
  input wire logic wb_cancel, // cancel
  input wire logic snoop_match_out, // match
  input wire logic snoop_modified_out, // modified
  input wire logic addr_parity_err_out, // perr
  input wire logic rd_valid, // beat
  input wire logic [63:0] data_in, // data
  input wire logic [7:0] data_par_in, // parity
  input wire logic data_parity_err_out // perr
);
  import bus_pipe_pkg::*;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  wire logic ap_bad = ^addr_in[28:2] ^ addr_parity_bit_in;
  wire line_t line_in = addr_in[28:2];
  logic d_bad;
  always_comb begin
    d_bad = 1'h0;
    for (int i = 0; i < 8; i++) d_bad |= ^{data_in[8*i+:8], data_par_in[i]};
  end
  property p_line;
    lookup_valid |-> lookup_line == $past(line_in) && lookup_drop == $past(snoop_drop_line);
  endproperty
  a_line: assert property (p_line) else $error("lookup line wrong");
  property p_match;
    lookup_valid |-> ##2 snoop_match_out == !$past(lookup_hit, 2);
  endproperty
  a_match: assert property (p_match) else $error("match wrong");
  property p_snoop_modified_out;
    lookup_valid && lookup_modified && !wb_cancel |-> ##2 snoop_modified_out;
  endproperty
  a_snoop_modified_out: assert property (p_snoop_modified_out) else $error("modified missing");
  property p_apar;
    lookup_valid |-> ##2 addr_parity_err_out == $past(ap_bad, 3);
  endproperty
  a_apar: assert property (p_apar) else $error("address parity wrong");
  property p_ignore;
    ext_snoop_strobe && (sram_mode || addr_oe || snoop_modified_out) |=> !lookup_valid;
  endproperty
  a_ignore: assert property (p_ignore) else $error("strobe not ignored");
  property p_src;
    $rose(snoop_modified_out) |-> $past(lookup_valid, 2) && $past(lookup_modified, 2);
  endproperty
  a_src: assert property (p_src) else $error("modified without inquiry");
  property p_float;
    cycle_start_strobe && $past(addr_float_req) |-> snoop_modified_out;
  endproperty
  a_float: assert property (p_float) else $error("start while floating");
  property p_dpar;
    data_parity_err_out |-> rd_valid && $past(d_bad);
  endproperty
  a_dpar: assert property (p_dpar) else $error("false data parity error");
  c_mod: cover property (lookup_valid && lookup_modified);
  c_float: cover property (cycle_start_strobe && addr_float_req);
  c_perr: cover property (data_parity_err_out);
endmodule
bind bus_pipe_snoop bus_pipe_snoop_props props (.*);

// ==== verification/bus_pipe_snoop_tb_top.sv ====
module bus_pipe_snoop_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bus_pipe_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
  logic clock = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0, req_atomic = 1'h0;
  logic req_wback = 1'h0, req_burst = 1'h1, req_taken, rd_valid, lookup_valid, lookup_drop;
  logic [7:0] req_be = 8'hFF, be_out, data_par_out, data_par_in;
  addr_t req_addr = '0, addr_in = '0, addr_out, sa;
  line_t lookup_line;
  logic [255:0] wr_line = '0, snoop_line_data = '0;
  logic [63:0] rd_data, data_out, data_in;
  logic attr_valid, attr_cacheable, attr_wb_policy, hold_grant_out, burst_ready, next_cycle_ok;
  logic lookup_hit = 1'h0, lookup_modified = 1'h0, wb_cancel = 1'h0, sram_mode = 1'h0;
  logic hold_req_in = 1'h0, addr_parity_bit_in = 1'h0, cacheable_in = 1'h0;
  logic cycle_start_strobe, cycle_write, atomic_seq_out, addr_parity_bit_out, addr_oe, data_oe;
  logic write_policy_in = 1'h0, addr_float_req = 1'h0, bus_backoff_in = 1'h0;
  logic ext_snoop_strobe = 1'h0, snoop_drop_line = 1'h0;
  logic data_parity_err_out, addr_parity_err_out, snoop_match_out, snoop_modified_out;
  logic na_en = 1'h0, slow = 1'h0, bad_par = 1'h0;
  logic [1:0] look_q = 2'h0;
  logic [64:0] q_rd[$];
  logic q_m[$];
  int err_total = 0, n_checks = 0, nrd = 0, n0;
  logic [31:0] kexp = 32'h0;
  bus_pipe_snoop dut (.*);
  chipset_model far (.*);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cacheable_in <= 1'($urandom);
    write_policy_in <= 1'($urandom);
    if (rd_valid === 1'h1) begin
      nrd++;
      `CHK(rd_data, q_rd[0][63:0])
      `CHK(data_parity_err_out, q_rd[0][64])
      void'(q_rd.pop_front());
    end
    if (look_q[1]) begin
      `CHK(snoop_match_out, q_m[0])
      void'(q_m.pop_front());
    end
    look_q <= {look_q[0], lookup_valid === 1'h1};
  end
  task automatic wrap_up;
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: sig = req_taken === 1'h1;
      1: sig = cycle_start_strobe === 1'h1;
      default: sig = snoop_modified_out === 1'h0;
    endcase
  endfunction
  task automatic waitfor(input int s);
    int i;
    for (i = 0; i < 200 && !sig(s); i++) @(posedge clock);
    if (!sig(s)) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic issue(input logic w, input logic last);
    req_write <= w;
    req_addr <= addr_t'($urandom);
    wr_line <= {8{$urandom}};
    req_valid <= 1'h1;
    repeat (4) begin
      if (!w) q_rd.push_back({bad_par, kexp, kexp});
      if (!w) kexp++;
    end
    @(posedge clock);
    waitfor(0);
    if (last) req_valid <= 1'h0;
  endtask
  task automatic snoop(input logic hit, input logic mod, input logic drop, input logic perr);
    sa = addr_t'($urandom);
    addr_in <= sa;
    addr_parity_bit_in <= ^sa[28:2] ^ perr;
    snoop_drop_line <= drop;
    lookup_hit <= hit;
    lookup_modified <= mod;
    snoop_line_data <= {8{$urandom}};
    ext_snoop_strobe <= 1'h1;
    q_m.push_back(!hit);
    @(posedge clock);
    ext_snoop_strobe <= 1'h0;
    addr_in <= ~sa;
    snoop_drop_line <= ~drop;
    tick(3);
    `CHK(addr_parity_err_out, perr)
  endtask
  initial begin
    void'($urandom(32'h3d9d));
    tick(6);
    rst_n <= 1'h1;
    tick(2);
    `CHK(snoop_match_out, 1'h1)
    na_en <= 1'h1;
    slow <= 1'h1;
    issue(1'h0, 1'h0);
    n0 = nrd;
    issue(1'h0, 1'h0);
    `CHK(nrd - n0 < 4, 1'h1)
    slow <= 1'h0;
    issue(1'h1, 1'h0);
    issue(1'h0, 1'h1);
    tick(40);
    bad_par <= 1'h1;
    slow <= 1'h1;
    tick(1);
    issue(1'h0, 1'h1);
    tick(20);
    bad_par <= 1'h0;
    addr_float_req <= 1'h1;
    tick(2);
    snoop(1'h0, 1'h0, 1'h0, 1'h0);
    snoop(1'h1, 1'h0, 1'h1, 1'h1);
    lookup_hit <= 1'h0;
    sram_mode <= 1'h1;
    ext_snoop_strobe <= 1'h1;
    tick(1);
    ext_snoop_strobe <= 1'h0;
    tick(3);
    sram_mode <= 1'h0;
    `CHK(snoop_match_out, 1'h0)
    snoop(1'h1, 1'h1, 1'h0, 1'h0);
    waitfor(1);
    `CHK(addr_oe, 1'h0)
    addr_float_req <= 1'h0;
    tick(2);
    `CHK(addr_oe, 1'h1)
    `CHK(addr_out, {sa[28:2], 2'h0})
    waitfor(2);
    bus_backoff_in <= 1'h1;
    slow <= 1'h0;
    tick(2);
    snoop(1'h1, 1'h1, 1'h1, 1'h0);
    `CHK(snoop_modified_out, 1'h1)
    wb_cancel <= 1'h1;
    waitfor(2);
    `CHK(cycle_start_strobe, 1'h0)
    wb_cancel <= 1'h0;
    bus_backoff_in <= 1'h0;
    tick(10);
    wrap_up();
  end
endmodule

// ==== verification/chipset_model.sv ====
module chipset_model (
  input wire logic clock, // clock
  input wire logic rst_n, // reset
  input wire logic cycle_start_strobe, // new cycle
  input wire logic cycle_write, // direction
  input wire logic na_en, // allow pipelining
  input wire logic slow, // wait states
  input wire logic bad_par, // corrupt parity
  output logic burst_ready, // beat done
  output logic next_cycle_ok, // next address
  output logic [63:0] data_in, // read data
  output logic [7:0] data_par_in // read parity
);
  logic [1:0] outst_q, beat_q, n, typ_q, typ_n;
  logic wait_q, fin, rdy;
  logic [31:0] k_q;
  logic [63:0] d;
  always_comb begin
    fin = burst_ready && beat_q == 2'h3;
    n = outst_q - 2'(fin) + 2'(cycle_start_strobe);
    typ_n = fin ? {1'h0, typ_q[1]} : typ_q;
    if (cycle_start_strobe) typ_n[outst_q[0] ^ fin] = cycle_write;
    rdy = n != 2'h0 && !(slow && !wait_q) && !(fin && outst_q == 2'h2 && ^typ_q);
    d = rdy && !typ_n[0] ? {k_q, k_q} : ~data_in;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      outst_q <= 2'h0;
      beat_q <= 2'h0;
      typ_q <= 2'h0;
      wait_q <= 1'h0;
      k_q <= 32'h0;
      burst_ready <= 1'h0;
      next_cycle_ok <= 1'h0;
      data_in <= 64'h0;
      data_par_in <= 8'h0;
    end else begin
      outst_q <= n;
      typ_q <= typ_n;
      wait_q <= !wait_q;
      beat_q <= beat_q + 2'(burst_ready);
      k_q <= k_q + 32'(rdy && !typ_n[0]);
      burst_ready <= rdy;
      next_cycle_ok <= na_en && n != 2'h0;
      data_in <= d;
      for (int i = 0; i < 8; i++) data_par_in[i] <= ^d[8*i+:8] ^ (i == 0 && bad_par);
    end
  end
endmodule
